//--- src/ssc_pkg.sv
// Shared constants and types of the synchronous SRAM control front end.
// Assumes one clock domain (clk, 40 MHz) and the 18-bit wide organisation.
package ssc_pkg;
    // Memory organisation: 2M words of two 9-bit lanes
    localparam int ADDR_W = 21;
    localparam int UPPER_W = 19;
    localparam int LANE_N = 2;
    localparam int DATA_W = 8;
    localparam int LANE_W = 9;
    localparam int WORD_W = 18;

    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LAST_ADDR = 8'h08;
    localparam logic [7:0] REG_WR_COUNT = 8'h0c;

    // Field positions
    localparam int CTRL_WPROT_BIT = 0;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_ILEAVE_BIT = 1;
    localparam int ST_CNT_LSB = 2;
    localparam int ST_DRIVE_BIT = 4;
    localparam int ST_WPROT_BIT = 5;

    // Values after reset
    localparam logic CTRL_WPROT_RST = 1'b0;
    localparam logic [31:0] WR_COUNT_RST = 32'h0000_0000;
    localparam logic [1:0] BURST_CNT_RST = 2'h0;

    // Access carried down the pipeline
    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } ssc_op_t;
endpackage

//--- src/ssc_mem.sv
// Word store for the SRAM front end, one write port with lane enables
// and one read port whose data come out of a register.
// Assumes both ports on clk; a same-address write forwards into the read.
`timescale 1ns/1ps
module ssc_mem (
    input wire logic clk,
    input wire logic rdEn,
    input wire logic [ssc_pkg::ADDR_W-1:0] rdAddr,
    output logic [ssc_pkg::WORD_W-1:0] rdData,
    input wire logic [ssc_pkg::LANE_N-1:0] wrLanes,
    input wire logic [ssc_pkg::ADDR_W-1:0] wrAddr,
    input wire logic [ssc_pkg::WORD_W-1:0] wrData
);
    import ssc_pkg::*;

    genvar g;
    generate
        for (g = 0; g < LANE_N; g++) begin : gLane
            // One array per lane, so each array has a single writer
            logic [LANE_W-1:0] laneStore [0:(1<<ADDR_W)-1];

            // Lane write and registered read with write-through forwarding
            always_ff @(posedge clk) begin
                if (wrLanes[g]) begin
                    laneStore[wrAddr] <= wrData[g*LANE_W +: LANE_W];
                end
                if (rdEn) begin
                    if (wrLanes[g] && (wrAddr == rdAddr)) begin
                        rdData[g*LANE_W +: LANE_W] <=
                            wrData[g*LANE_W +: LANE_W];
                    end else begin
                        rdData[g*LANE_W +: LANE_W] <= laneStore[rdAddr];
                    end
                end
            end
        end
    endgenerate
endmodule

//--- src/ssc_top.sv
// Synchronous pipelined SRAM: control inputs, burst counter, data lanes
// and an AHB-Lite register slave for control and status.
// Assumes host logic on clk drives the synchronous pins; output enable
// and the burst-order strap arrive unsynchronised.
//
// Functional notes
// - Capture full address, both low bits, per edge
// - Lane written only with lane select and strobe
// - Each lane select covers data plus parity
// - Write strobe sampled only on qualified edges
// - Advance high with gate low steps counter
// - Advance low loads new address
// - Edges acted on only with gate low
// - Gate high holds state, no deselect
// - Selected only when selects are low-high-low
// - Outputs off: write data, after deselect, deselected
// - Strap high interleaved, low linear burst
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ssc_top (
    input wire logic clk,
    input wire logic rst,
    // SRAM pins
    input wire logic [ssc_pkg::UPPER_W-1:0] addrUpper,
    input wire logic addrBit1,
    input wire logic addrBit0,
    input wire logic chipSelFirstN,
    input wire logic chipSelSecond,
    input wire logic chipSelThirdN,
    input wire logic clockGateN,
    input wire logic advanceOrLoad,
    input wire logic writeStrobeN,
    input wire logic lane0WriteSelN,
    input wire logic lane1WriteSelN,
    input wire logic outEnableN,
    input wire logic burstModeStrap,
    input wire logic [ssc_pkg::DATA_W-1:0] lane0DataIn,
    output logic [ssc_pkg::DATA_W-1:0] lane0DataOut,
    output logic lane0DataOe,
    input wire logic lane0ParityIn,
    output logic lane0ParityOut,
    output logic lane0ParityOe,
    input wire logic [ssc_pkg::DATA_W-1:0] lane1DataIn,
    output logic [ssc_pkg::DATA_W-1:0] lane1DataOut,
    output logic lane1DataOe,
    input wire logic lane1ParityIn,
    output logic lane1ParityOut,
    output logic lane1ParityOe,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import ssc_pkg::*;

    // Burst low address bits: xor for interleaved, sum for linear
    function automatic logic [1:0] burstLow(input logic [1:0] base,
                                            input logic [1:0] cnt,
                                            input logic ileave);
        burstLow = ileave ? (base ^ cnt) : 2'(base + cnt);
    endfunction

    // Register offset decode, shared by the read and write paths
    function automatic logic [1:0] regSlot(input logic [7:0] off);
        case (off)
            REG_CTRL: regSlot = 2'h0;
            REG_STATUS: regSlot = 2'h1;
            REG_LAST_ADDR: regSlot = 2'h2;
            default: regSlot = 2'h3;
        endcase
    endfunction

    logic oeSync1_r, oeSync2_r, modeSync1_r, modeSync2_r;
    logic step;
    logic selected;
    logic [ADDR_W-1:0] pinAddr;
    logic [LANE_N-1:0] laneSelN, laneWr;
    logic [1:0] cntNext;
    logic [ADDR_W-1:0] base_r;
    logic [1:0] cnt_r;
    ssc_op_t aOp_r, bOp_r;
    logic [ADDR_W-1:0] aAddr_r, bAddr_r;
    logic [LANE_N-1:0] aLanes_r, bLanes_r;
    logic cRead_r;
    logic [WORD_W-1:0] memRd, pinWord, drvWord_r;
    logic [LANE_N-1:0] memWr;
    logic drive_r;
    logic wprot_r;
    logic [31:0] wrCount_r;
    logic wrPend_r;
    logic [1:0] wrSlot_r;
    logic addrPhase;
    logic [31:0] rdMux;

    // Asynchronous output enable and strap pass two flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            oeSync1_r <= 1'b1;
            oeSync2_r <= 1'b1;
            modeSync1_r <= 1'b1;
            modeSync2_r <= 1'b1;
        end else begin
            oeSync1_r <= outEnableN;
            oeSync2_r <= oeSync1_r;
            modeSync1_r <= burstModeStrap;
            modeSync2_r <= modeSync1_r;
        end
    end

    // Qualified edge, chip select and lane decode
    assign step = !clockGateN;
    assign selected = !chipSelFirstN && chipSelSecond
                      && !chipSelThirdN;
    assign pinAddr = {addrUpper, addrBit1, addrBit0};
    assign laneSelN = {lane1WriteSelN, lane0WriteSelN};
    assign laneWr = ~laneSelN & {LANE_N{!writeStrobeN}};
    assign cntNext = 2'(cnt_r + 2'h1);

    // Address stage: load, advance or deselect; holds while gate is high
    always_ff @(posedge clk) begin
        if (rst) begin
            aOp_r <= OP_NONE;
            aAddr_r <= '0;
            aLanes_r <= '0;
            base_r <= '0;
            cnt_r <= BURST_CNT_RST;
        end else if (step) begin
            if (!advanceOrLoad) begin
                base_r <= pinAddr;
                cnt_r <= BURST_CNT_RST;
                aAddr_r <= pinAddr;
                aLanes_r <= laneWr;
                if (!selected) begin
                    aOp_r <= OP_NONE;
                end else if (!writeStrobeN) begin
                    aOp_r <= OP_WRITE;
                end else begin
                    aOp_r <= OP_READ;
                end
            end else if (aOp_r != OP_NONE) begin
                cnt_r <= cntNext;
                aAddr_r <= {base_r[ADDR_W-1:2],
                            burstLow(base_r[1:0], cntNext,
                                     modeSync2_r)};
                aLanes_r <= laneWr;
            end else begin
                aOp_r <= OP_NONE;
            end
        end
    end

    // Second stage: memory read issued, write waits for its data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            bOp_r <= OP_NONE;
            bAddr_r <= '0;
            bLanes_r <= '0;
            cRead_r <= 1'b0;
        end else if (step) begin
            bOp_r <= aOp_r;
            bAddr_r <= aAddr_r;
            bLanes_r <= aLanes_r;
            cRead_r <= (bOp_r == OP_READ);
        end
    end

    // Write data taken from the pins in the data phase, lane by lane
    assign pinWord = {lane1ParityIn, lane1DataIn, lane0ParityIn, lane0DataIn};
    assign memWr = (step && bOp_r == OP_WRITE && !wprot_r) ?
                   bLanes_r : '0;

    ssc_mem uMem (
        .clk(clk),
        .rdEn(step),
        .rdAddr(aAddr_r),
        .rdData(memRd),
        .wrLanes(memWr),
        .wrAddr(bAddr_r),
        .wrData(pinWord)
    );

    // Read data register, loaded in the read's data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            drvWord_r <= '0;
        end else if (step && bOp_r == OP_READ) begin
            drvWord_r <= memRd;
        end
    end

    // Pin drive only for a read data phase with output enable low
    always_ff @(posedge clk) begin
        if (rst) begin
            drive_r <= 1'b0;
        end else if (step) begin
            drive_r <= (bOp_r == OP_READ) && !oeSync2_r;
        end else begin
            drive_r <= cRead_r && !oeSync2_r;
        end
    end

    assign lane0DataOut = drvWord_r[DATA_W-1:0];
    assign lane0ParityOut = drvWord_r[DATA_W];
    assign lane1DataOut = drvWord_r[LANE_W +: DATA_W];
    assign lane1ParityOut = drvWord_r[LANE_W+DATA_W];
    assign lane0DataOe = drive_r;
    assign lane0ParityOe = drive_r;
    assign lane1DataOe = drive_r;
    assign lane1ParityOe = drive_r;

    // AHB-Lite: zero wait state, always OKAY
    assign addrPhase = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Read multiplexer, forwarding a control write still in data phase
    always_comb begin
        rdMux = 32'h0000_0000;
        case (regSlot(haddr[7:0]))
            2'h0: begin
                rdMux[CTRL_WPROT_BIT] = (wrPend_r && wrSlot_r == 2'h0) ?
                                        hwdata[CTRL_WPROT_BIT] : wprot_r;
            end
            2'h1: begin
                rdMux[ST_ACTIVE_BIT] = (aOp_r != OP_NONE);
                rdMux[ST_ILEAVE_BIT] = modeSync2_r;
                rdMux[ST_CNT_LSB +: 2] = cnt_r;
                rdMux[ST_DRIVE_BIT] = drive_r;
                rdMux[ST_WPROT_BIT] = wprot_r;
            end
            2'h2: rdMux[ADDR_W-1:0] = base_r;
            default: begin
                rdMux = (haddr[7:0] == REG_WR_COUNT) ? wrCount_r : 32'h0;
            end
        endcase
        if (|haddr[31:8]) begin
            rdMux = 32'h0000_0000;
        end
    end

    // Address phase capture and read data register
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_r <= 1'b0;
            wrSlot_r <= 2'h3;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend_r <= addrPhase && hwrite && !(|haddr[31:8]);
            wrSlot_r <= regSlot(haddr[7:0]);
            if (addrPhase && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    // Control register: write protect gates array writes
    always_ff @(posedge clk) begin
        if (rst) begin
            wprot_r <= CTRL_WPROT_RST;
        end else if (wrPend_r && wrSlot_r == 2'h0) begin
            wprot_r <= hwdata[CTRL_WPROT_BIT];
        end
    end

    // Count of write data phases that stored at least one lane
    always_ff @(posedge clk) begin
        if (rst) begin
            wrCount_r <= WR_COUNT_RST;
        end else if (|memWr) begin
            wrCount_r <= wrCount_r + 32'h0000_0001;
        end
    end
endmodule

//--- bench/ssc_props.sv
// Concurrent checks on the pins and bus of ssc_top.
// Assumes one clock, clk, and the synchronous active-high reset rst.
`timescale 1ns/1ps
module ssc_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic chipSelFirstN,
    input wire logic chipSelSecond,
    input wire logic chipSelThirdN,
    input wire logic clockGateN,
    input wire logic advanceOrLoad,
    input wire logic writeStrobeN,
    input wire logic outEnableN,
    input wire logic [ssc_pkg::DATA_W-1:0] lane0DataOut,
    input wire logic [ssc_pkg::DATA_W-1:0] lane1DataOut,
    input wire logic lane0DataOe,
    input wire logic lane0ParityOe,
    input wire logic lane1DataOe,
    input wire logic lane1ParityOe,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    import ssc_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic sel;
    logic ld;
    // Qualified load and full select
    assign sel = !chipSelFirstN && chipSelSecond && !chipSelThirdN;
    assign ld = !clockGateN && !advanceOrLoad;
    sequence twoEdges;
        !clockGateN ##1 !clockGateN;
    endsequence
    chk_write_quiet: assert property (
        ld && sel && !writeStrobeN ##1 twoEdges |=> !lane0DataOe)
        else $error("pins driven in write data phase");
    chk_desel_quiet: assert property (
        ld && !sel ##1 twoEdges |=> !lane0DataOe && !lane1DataOe)
        else $error("pins driven while deselected");
    chk_read_drive: assert property (
        (!outEnableN) [*4] ##0 ld && sel && writeStrobeN
        ##1 twoEdges |=> lane0DataOe)
        else $error("read data not driven");
    chk_oe_off: assert property (
        outEnableN [*4] |=> !lane0DataOe && !lane1DataOe)
        else $error("pins driven with output enable off");
    chk_gate_hold: assert property (
        clockGateN |=> $stable(lane0DataOut) && $stable(lane1DataOut))
        else $error("output moved on a gated edge");
    chk_lanes_paired: assert property (
        lane0ParityOe == lane0DataOe && lane1ParityOe == lane1DataOe
        && lane1DataOe == lane0DataOe)
        else $error("lane drive enables differ");
    chk_unmapped_zero: assert property (
        hsel && htrans[1] && hready && !hwrite && haddr[31:4] != 0
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    // Main scenarios
    cov_write_load: cover property (ld && sel && !writeStrobeN);
    cov_burst_step: cover property (!clockGateN && advanceOrLoad);
    cov_gate_stall: cover property (clockGateN ##1 !clockGateN);
endmodule

bind ssc_top ssc_props chk (.clk, .rst, .chipSelFirstN, .chipSelSecond,
    .chipSelThirdN, .clockGateN, .advanceOrLoad, .writeStrobeN, .outEnableN,
    .lane0DataOut, .lane1DataOut, .lane0DataOe, .lane0ParityOe, .lane1DataOe,
    .lane1ParityOe, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp);

//--- bench/ssc_host.sv
// Host controller model driving the synchronous SRAM pins.
// Assumes the bench calls step once a clock; pins change after edges.
`timescale 1ns/1ps
module ssc_host (
    input wire logic clk,
    output logic [ssc_pkg::UPPER_W-1:0] addrUpper,
    output logic addrBit1,
    output logic addrBit0,
    output logic chipSelFirstN,
    output logic chipSelSecond,
    output logic chipSelThirdN,
    output logic clockGateN,
    output logic advanceOrLoad,
    output logic writeStrobeN,
    output logic lane0WriteSelN,
    output logic lane1WriteSelN,
    output logic [ssc_pkg::DATA_W-1:0] lane0DataIn,
    output logic lane0ParityIn,
    output logic [ssc_pkg::DATA_W-1:0] lane1DataIn,
    output logic lane1ParityIn
);
    import ssc_pkg::*;
    // Idle: gate on, deselected, loading, no write
    initial begin
        {addrUpper, addrBit1, addrBit0} = '0;
        {chipSelFirstN, chipSelSecond, chipSelThirdN} = 3'b101;
        {clockGateN, advanceOrLoad, writeStrobeN} = 3'b001;
        {lane1WriteSelN, lane0WriteSelN} = 2'b11;
        {lane1ParityIn, lane1DataIn, lane0ParityIn, lane0DataIn} = '0;
    end
    // One clock: gate, selects, advance, write, address, lanes, pin word
    task automatic step(input logic g, input logic [2:0] cs, input logic v,
        input logic w, input logic [ADDR_W-1:0] a,
        input logic [LANE_N-1:0] ln, input logic [WORD_W-1:0] d);
        @(posedge clk);
        clockGateN <= !g;
        {chipSelFirstN, chipSelSecond, chipSelThirdN} <= cs;
        advanceOrLoad <= v;
        writeStrobeN <= !w;
        {addrUpper, addrBit1, addrBit0} <= a;
        {lane1WriteSelN, lane0WriteSelN} <= ~ln;
        {lane1ParityIn, lane1DataIn, lane0ParityIn, lane0DataIn} <= d;
    endtask
endmodule

//--- bench/sync_sram_control_inputs_bench.sv
// Bench for the SRAM front end: host pins via ssc_host, AHB-Lite here.
// Assumes ssc_props is bound to ssc_top.
`timescale 1ns/1ps
module sync_sram_control_inputs_bench;
    import ssc_pkg::*;
    localparam logic [2:0] SEL = 3'b010;
    localparam logic [2:0] DES = 3'b101;
    localparam logic [ADDR_W-1:0] BASE = 21'h0a5c1;
    logic clk = 1'b0;
    logic rst, burstModeStrap, outEnableN, hsel, hwrite, hready;
    logic hreadyout, hresp, addrBit1, addrBit0, chipSelFirstN, chipSelSecond;
    logic chipSelThirdN, clockGateN, advanceOrLoad, writeStrobeN;
    logic lane0WriteSelN, lane1WriteSelN, lane0ParityIn, lane1ParityIn;
    logic lane0ParityOut, lane1ParityOut, lane0DataOe, lane1DataOe;
    logic lane0ParityOe, lane1ParityOe;
    logic [DATA_W-1:0] lane0DataIn, lane1DataIn, lane0DataOut, lane1DataOut;
    logic [UPPER_W-1:0] addrUpper;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, cnt, junk;
    logic [WORD_W-1:0] rdw;
    int nFail = 0;
    int totalChecks = 0;
    // Clock, bus ready loop and read word
    always #12.5 clk = ~clk;
    assign hready = hreadyout;
    assign rdw = {lane1ParityOut, lane1DataOut, lane0ParityOut, lane0DataOut};
    ssc_top DUT (.clk, .rst, .addrUpper, .addrBit1, .addrBit0, .chipSelFirstN,
        .chipSelSecond, .chipSelThirdN, .clockGateN, .advanceOrLoad,
        .writeStrobeN, .lane0WriteSelN, .lane1WriteSelN, .outEnableN,
        .burstModeStrap, .lane0DataIn, .lane0DataOut, .lane0DataOe,
        .lane0ParityIn, .lane0ParityOut, .lane0ParityOe, .lane1DataIn,
        .lane1DataOut, .lane1DataOe, .lane1ParityIn, .lane1ParityOut,
        .lane1ParityOe, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp);
    ssc_host hst (.clk, .addrUpper, .addrBit1, .addrBit0, .chipSelFirstN,
        .chipSelSecond, .chipSelThirdN, .clockGateN, .advanceOrLoad,
        .writeStrobeN, .lane0WriteSelN, .lane1WriteSelN, .lane0DataIn,
        .lane0ParityIn, .lane1DataIn, .lane1ParityIn);
    task automatic testDone;
        $display("checks %0d, mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        totalChecks++;
        if (seen !== want) begin
            nFail++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            nFail++;
            testDone;
        end
    endtask
    // Single AHB-Lite word transfer
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(a);
        waitRdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        waitRdy();
        rd = hrdata;
    endtask
    task automatic rr(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    // One access: address cycle, optional gated stall, two pipe stages
    task automatic acc(input logic w, input logic [2:0] cs,
        input logic [ADDR_W-1:0] a, input logic [1:0] ln,
        input logic [WORD_W-1:0] d, input int st);
        hst.step(1, cs, 0, w, a, ln, ~d);
        repeat (st) hst.step(0, 3'b111, 1, 1, ~a, 2'b11, d);
        hst.step(1, DES, 0, 0, a, 0, ~d);
        hst.step(1, DES, 0, 0, a, 0, w ? d : ~d);
        hst.step(1, DES, 0, 0, a, 0, ~d);
        #1;
    endtask
    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [17:0] e);
        acc(1'b0, SEL, a, 2'b00, ~e, 0);
        chk(32'(rdw), 32'(e));
        chk(32'(lane1DataOe), 32'h1);
    endtask
    // Four writes around BASE, data d0 plus the low address bits
    task automatic fill(input logic [WORD_W-1:0] d0);
        for (int k = 0; k < 4; k++)
            acc(1, SEL, {BASE[20:2], 2'(k)}, 2'b11, d0 + 18'(k), 0);
        cnt += 4;
    endtask
    // One load and three advances; order follows the strap
    task automatic burst(input logic [WORD_W-1:0] d0);
        logic [1:0] k;
        for (int i = 0; i < 7; i++) begin
            hst.step(1, i == 0 ? SEL : DES, i > 0 && i < 4, 0, BASE, 0, 0);
            k = burstModeStrap ? BASE[1:0] ^ 2'(i - 3)
                : BASE[1:0] + 2'(i - 3);
            #1;
            if (i >= 3) chk(32'(rdw), 32'(d0 + 18'(k)));
        end
    endtask
    // Main sequence
    initial begin
        {rst, burstModeStrap, outEnableN, hsel, hwrite} = 5'b11000;
        {htrans, haddr, hwdata, cnt} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rr(REG_CTRL, 32'h0);
        rr(REG_WR_COUNT, 32'h0);
        rr(8'h10, 32'h0);
        ahb(1'b1, REG_WR_COUNT, 32'h55, junk);
        rr(REG_WR_COUNT, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0, junk);
        chk(32'(junk[ST_ILEAVE_BIT]), 32'h1);
        fill(18'h25a50);
        burst(18'h25a50);
        rr(REG_LAST_ADDR, 32'(BASE));
        acc(1, SEL, BASE, 2'b11, 18'h3c3c3, 0);
        acc(1, SEL, BASE, 2'b10, 18'h12345, 2);
        acc(0, SEL, BASE, 2'b11, 18'h0, 0);
        rdChk(BASE, 18'h12345 & 18'h3fe00 | 18'h3c3c3 & 18'h001ff);
        cnt += 2;
        rr(REG_WR_COUNT, cnt);
        for (int c = 0; c < 8; c++) begin
            acc(1, 3'(c), BASE, 2'b11, 18'h01000 + 18'(c), 0);
            cnt += (c == 2);
            rr(REG_WR_COUNT, cnt);
        end
        rdChk(BASE, 18'h01002);
        ahb(1'b1, REG_CTRL, 32'h1, junk);
        rr(REG_CTRL, 32'h1);
        acc(1, SEL, BASE, 2'b11, 18'h0, 0);
        rdChk(BASE, 18'h01002);
        rr(REG_WR_COUNT, cnt);
        ahb(1'b1, REG_CTRL, 32'h0, junk);
        @(posedge clk);
        outEnableN <= 1'b1;
        acc(0, SEL, BASE, 2'b00, 18'h0, 3);
        chk(32'(lane0DataOe), 32'h0);
        @(posedge clk);
        {rst, burstModeStrap, outEnableN} <= 3'b100;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(32'(rdw), 32'h0);
        chk(32'(lane0DataOe), 32'h0);
        cnt = 0;
        rr(REG_WR_COUNT, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0, junk);
        chk(32'(junk[ST_ILEAVE_BIT]), 32'h0);
        // Fresh data so no word left from the first run can pass
        fill(18'h1a5a0);
        rr(REG_WR_COUNT, cnt);
        burst(18'h1a5a0);
        testDone;
    end
endmodule
